// ### hbs_field.sv
// Field model: switch, sensors and a burner whose flame follows fuel and spark
`timescale 1ns/100ps
`default_nettype none
module hbs_field (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire hbs_pkg::hbs_drv_s drv, // Actuator drives
  input wire logic sw, // Operator switch
  input wire logic aux, // Auxiliary pump request
  input wire logic lights, // Burner able to light
  input wire logic [7:0] cfault, // Component fault flags
  input wire logic [11:0] temp, // Coolant outlet temperature
  input wire logic [2:0] sysf, // System faults: flow, overheat, voltage
  output hbs_pkg::hbs_pins_s pins // Field inputs to the sequencer
);
  import hbs_pkg::*;
  logic flame_r;
  // Flame needs fuel, and a spark to catch; it dies when fuel stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flame_r <= 1'b0;
    else flame_r <= drv.fuel_valve && lights && (drv.spark || flame_r);
  end
  // Pin bundle; system monitor inputs come from the bench
  assign pins = '{switch_on: sw, aux_pump: aux, flame_ok: flame_r, flow_fault: sysf[2],
    overheat: sysf[1], volt_fault: sysf[0], comp_fault: cfault, outlet_temp_sensor: temp};
endmodule
`default_nettype wire

// ### hbs_flash.sv
// Fault code flasher: repeats a series of lamp pulses, count equal to the code
`timescale 1ns/100ps
`default_nettype none
module hbs_flash #(
  parameter logic [hbs_pkg::TW-1:0] ON_CYC = hbs_pkg::FLASH_ON_CYC,
  parameter logic [hbs_pkg::TW-1:0] GAP_CYC = hbs_pkg::FLASH_GAP_CYC,
  parameter logic [hbs_pkg::TW-1:0] PAUSE_CYC = hbs_pkg::FLASH_PAUSE_CYC
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [3:0] code, // Code to flash, zero for none
  output logic lamp // Indicator drive
);
  import hbs_pkg::*;

  hbs_flash_e st_r;
  logic [TW-1:0] tmr_r;
  logic [3:0] cnt_r;

  if (ON_CYC == '0 || GAP_CYC == '0 || PAUSE_CYC == '0) begin : g_bad
    $error("hbs_flash: flash times must be at least one cycle");
  end

  // Pulse, gap and pause sequencing with a registered lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= F_IDLE;
      tmr_r <= '0;
      cnt_r <= 4'h0;
      lamp <= 1'b0;
    end else begin
      case (st_r)
        F_IDLE: begin
          lamp <= 1'b0;
          if (code != CODE_NONE) begin
            st_r <= F_ON;
            tmr_r <= '0;
            cnt_r <= 4'h1;
            lamp <= 1'b1;
          end
        end
        F_ON: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == ON_CYC - 1'b1) begin
            lamp <= 1'b0;
            tmr_r <= '0;
            st_r <= (cnt_r >= code) ? F_PAUSE : F_GAP;
          end
        end
        F_GAP: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == GAP_CYC - 1'b1) begin
            tmr_r <= '0;
            cnt_r <= cnt_r + 4'h1;
            lamp <= 1'b1;
            st_r <= F_ON;
          end
        end
        F_PAUSE: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == PAUSE_CYC - 1'b1) begin
            tmr_r <= '0;
            st_r <= F_IDLE;
          end
        end
        default: st_r <= F_IDLE;
      endcase
      if (code == CODE_NONE) begin
        st_r <= F_IDLE;
        lamp <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### hbs_pkg.sv
// Package of constants, types and timing counts for the heater burner sequencer
package hbs_pkg;

  // Clock rate and timer width
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam int TW = 36;

  // Documented and chosen times, in their own units
  localparam longint unsigned SPARK_TEST_S = 5;
  localparam longint unsigned IGN_S = 30;
  localparam longint unsigned COOL_MIN = 3;
  localparam longint unsigned STEP_MS = 100;
  localparam longint unsigned DEB_MS = 10;
  localparam longint unsigned FLASH_ON_MS = 500;
  localparam longint unsigned FLASH_GAP_MS = 500;
  localparam longint unsigned FLASH_PAUSE_MS = 3000;

  // Cycle counts derived from the times
  localparam logic [TW-1:0] SPARK_TEST_CYC = TW'(SPARK_TEST_S * CLK_HZ);
  localparam logic [TW-1:0] IGN_CYC = TW'(IGN_S * CLK_HZ);
  localparam logic [TW-1:0] COOL_CYC = TW'(COOL_MIN * 60 * CLK_HZ);
  localparam logic [TW-1:0] STEP_CYC = TW'(STEP_MS * CLK_HZ / 1000);
  localparam logic [TW-1:0] DEB_CYC = TW'(DEB_MS * CLK_HZ / 1000);
  localparam logic [TW-1:0] FLASH_ON_CYC = TW'(FLASH_ON_MS * CLK_HZ / 1000);
  localparam logic [TW-1:0] FLASH_GAP_CYC = TW'(FLASH_GAP_MS * CLK_HZ / 1000);
  localparam logic [TW-1:0] FLASH_PAUSE_CYC = TW'(FLASH_PAUSE_MS * CLK_HZ / 1000);

  // Temperatures in degrees F, one count per degree
  localparam int TEMP_W = 12;
  localparam logic [TEMP_W-1:0] START_TEMP_RST = 12'h0a0;
  localparam logic [TEMP_W-1:0] HIGH_TEMP_RST = 12'h0b9;
  localparam logic [TEMP_W-1:0] CYCLE_ON_RST = 12'h096;
  localparam logic [TEMP_W-1:0] HYST_RST = 12'h002;
  localparam logic [TEMP_W-1:0] TEMP_MIN_VALID = 12'h001;
  localparam logic [TEMP_W-1:0] TEMP_MAX_VALID = 12'hffe;

  // Register byte offsets
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_HIGH = 8'h04;
  localparam logic [7:0] OFF_CYCON = 8'h08;
  localparam logic [7:0] OFF_HYST = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_TEMP = 8'h14;

  // Status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_ATT_BIT = 4;
  localparam int ST_CODE_LSB = 8;
  localparam int ST_OUT_LSB = 16;

  // Fault flash codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_START = 4'h1;
  localparam logic [3:0] CODE_FLAME_OUT = 4'h2;
  localparam logic [3:0] CODE_FLOW = 4'h3;
  localparam logic [3:0] CODE_OVERHEAT = 4'h4;
  localparam logic [3:0] CODE_VOLTAGE = 4'h5;
  localparam logic [3:0] CODE_FLAME_FAULT = 4'h6;
  localparam logic [3:0] CODE_COMP_BASE = 4'h7;
  localparam int N_COMP = 8;

  // Sequencer and flasher states
  typedef enum logic [2:0] {
    S_OFF, S_PRECHECK, S_IGNITION, S_FULL, S_COOLDOWN, S_STANDBY, S_FAULT
  } hbs_state_e;
  typedef enum logic [1:0] {F_IDLE, F_ON, F_GAP, F_PAUSE} hbs_flash_e;

  // Field pins from switch, sensors and load monitors
  typedef struct packed {
    logic switch_on;
    logic aux_pump;
    logic flame_ok;
    logic flow_fault;
    logic overheat;
    logic volt_fault;
    logic [N_COMP-1:0] comp_fault;
    logic [TEMP_W-1:0] outlet_temp_sensor;
  } hbs_pins_s;

  // Actuator drives
  typedef struct packed {
    logic blower;
    logic pump;
    logic spark;
    logic fuel_valve;
    logic lamp;
  } hbs_drv_s;

endpackage

// ### hbs_seq.sv
// Heater burner sequencer: start, run, cool down, standby and fault latch
`timescale 1ns/100ps
`default_nettype none
module hbs_seq #(
  parameter logic [hbs_pkg::TW-1:0] SPARK_TEST_CYC = hbs_pkg::SPARK_TEST_CYC,
  parameter logic [hbs_pkg::TW-1:0] IGN_CYC = hbs_pkg::IGN_CYC,
  parameter logic [hbs_pkg::TW-1:0] COOL_CYC = hbs_pkg::COOL_CYC,
  parameter logic [hbs_pkg::TW-1:0] STEP_CYC = hbs_pkg::STEP_CYC,
  parameter logic [hbs_pkg::TW-1:0] DEB_CYC = hbs_pkg::DEB_CYC,
  parameter logic [hbs_pkg::TW-1:0] FLASH_ON_CYC = hbs_pkg::FLASH_ON_CYC,
  parameter logic [hbs_pkg::TW-1:0] FLASH_GAP_CYC = hbs_pkg::FLASH_GAP_CYC,
  parameter logic [hbs_pkg::TW-1:0] FLASH_PAUSE_CYC = hbs_pkg::FLASH_PAUSE_CYC
) (
  input wire logic pclk, // Clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire hbs_pkg::hbs_pins_s pins, // Field inputs
  output hbs_pkg::hbs_drv_s drv // Actuator drives
);
  import hbs_pkg::*;

  if (IGN_CYC <= 2 * STEP_CYC || COOL_CYC == '0 || SPARK_TEST_CYC == '0 || DEB_CYC == '0)
  begin : g_bad
    $error("hbs_seq: timing parameters cannot be served");
  end

  hbs_pins_s sync1_r, sync2_r;
  logic [TEMP_W-1:0] start_r, high_r, cycon_r, hyst_r;
  logic [TEMP_W-1:0] temp_r, cand_r;
  logic [TW-1:0] deb_r;
  logic warm_r, hot_r, cool_r;
  hbs_state_e st_r;
  logic [TW-1:0] tmr_r;
  logic first_r, retry_r, att_r;
  logic [3:0] code_r, pend_r;
  logic [3:0] comp_code;
  logic comp_any, temp_bad, sys_fault;
  logic [3:0] sys_code;
  logic blower_r, pump_r, spark_r, valve_r;
  logic lamp;

  // Two-flop synchroniser on all field inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // Temperature debounce: a new reading is taken once it holds steady
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_r <= '0;
      temp_r <= '0;
      deb_r <= '0;
    end else if (sync2_r.outlet_temp_sensor != cand_r) begin
      cand_r <= sync2_r.outlet_temp_sensor;
      deb_r <= '0;
    end else if (deb_r == DEB_CYC - 1'b1) begin
      temp_r <= cand_r;
      deb_r <= deb_r;
    end else begin
      deb_r <= deb_r + 1'b1;
    end
  end

  // Threshold flags with hysteresis bands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_r <= 1'b0;
      hot_r <= 1'b0;
      cool_r <= 1'b0;
    end else begin
      if (temp_r > start_r + hyst_r) warm_r <= 1'b1;
      else if (temp_r < start_r) warm_r <= 1'b0;
      if (temp_r >= high_r) hot_r <= 1'b1;
      else if (temp_r + hyst_r < high_r) hot_r <= 1'b0;
      if (temp_r <= cycon_r) cool_r <= 1'b1;
      else if (temp_r > cycon_r + hyst_r) cool_r <= 1'b0;
    end
  end

  // Component fault encoder, lowest index wins
  always_comb begin
    comp_code = CODE_NONE;
    comp_any = 1'b0;
    for (int i = N_COMP - 1; i >= 0; i--) begin
      if (sync2_r.comp_fault[i]) begin
        comp_code = CODE_COMP_BASE + 4'(i);
        comp_any = 1'b1;
      end
    end
  end

  // Range check of the outlet sensor and system fault selection
  assign temp_bad = (temp_r < TEMP_MIN_VALID) || (temp_r > TEMP_MAX_VALID);
  assign sys_fault = sync2_r.flow_fault || sync2_r.overheat || sync2_r.volt_fault;
  always_comb begin
    if (sync2_r.flow_fault) sys_code = CODE_FLOW;
    else if (sync2_r.overheat) sys_code = CODE_OVERHEAT;
    else sys_code = CODE_VOLTAGE;
  end

  // Main burner sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_OFF;
      tmr_r <= '0;
      first_r <= 1'b0;
      retry_r <= 1'b0;
      att_r <= 1'b0;
      pend_r <= CODE_NONE;
      code_r <= CODE_NONE;
    end else begin
      tmr_r <= tmr_r + 1'b1;
      case (st_r)
        S_OFF: begin
          tmr_r <= '0;
          code_r <= CODE_NONE;
          att_r <= 1'b0;
          retry_r <= 1'b0;
          first_r <= 1'b1;
          if (sync2_r.switch_on) begin
            st_r <= warm_r ? S_STANDBY : S_PRECHECK;
          end
        end
        S_PRECHECK: begin
          if (!sync2_r.switch_on) begin
            st_r <= S_OFF;
          end else if (comp_any || temp_bad) begin
            code_r <= comp_any ? comp_code : CODE_COMP_BASE;
            st_r <= S_FAULT;
          end else if (sync2_r.flame_ok && !spark_r) begin
            code_r <= CODE_FLAME_FAULT;
            st_r <= S_FAULT;
          end else if (!first_r || tmr_r == SPARK_TEST_CYC - 1'b1) begin
            first_r <= 1'b0;
            tmr_r <= '0;
            st_r <= S_IGNITION;
          end
        end
        S_IGNITION: begin
          if (!sync2_r.switch_on) begin
            retry_r <= 1'b0;
            tmr_r <= '0;
            st_r <= S_COOLDOWN;
          end else if (comp_any) begin
            code_r <= comp_code;
            st_r <= S_FAULT;
          end else if (tmr_r == IGN_CYC - 1'b1) begin
            tmr_r <= '0;
            if (sync2_r.flame_ok) begin
              st_r <= S_FULL;
            end else if (att_r) begin
              code_r <= CODE_START;
              st_r <= S_FAULT;
            end else begin
              att_r <= 1'b1;
              retry_r <= 1'b1;
              st_r <= S_COOLDOWN;
            end
          end
        end
        S_FULL: begin
          tmr_r <= '0;
          if (!sync2_r.switch_on) begin
            retry_r <= 1'b0;
            st_r <= S_COOLDOWN;
          end else if (comp_any) begin
            code_r <= comp_code;
            st_r <= S_FAULT;
          end else if (!sync2_r.flame_ok || sys_fault) begin
            if (att_r) begin
              code_r <= sync2_r.flame_ok ? sys_code : CODE_FLAME_OUT;
              st_r <= S_FAULT;
            end else begin
              pend_r <= sync2_r.flame_ok ? sys_code : CODE_FLAME_OUT;
              att_r <= 1'b1;
              retry_r <= 1'b1;
              st_r <= S_COOLDOWN;
            end
          end else if (hot_r) begin
            retry_r <= 1'b0;
            st_r <= S_COOLDOWN;
          end
        end
        S_COOLDOWN: begin
          if (tmr_r == COOL_CYC - 1'b1) begin
            tmr_r <= '0;
            if (!sync2_r.switch_on) st_r <= S_OFF;
            else if (retry_r) st_r <= S_PRECHECK;
            else st_r <= S_STANDBY;
          end
        end
        S_STANDBY: begin
          tmr_r <= '0;
          if (!sync2_r.switch_on) st_r <= S_OFF;
          else if (cool_r) begin
            att_r <= 1'b0;
            st_r <= S_PRECHECK;
          end
        end
        S_FAULT: begin
          tmr_r <= '0;
          if (!sync2_r.switch_on) st_r <= S_OFF;
        end
        default: st_r <= S_OFF;
      endcase
    end
  end

  // Actuator drives decoded from state and ignition step timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blower_r <= 1'b0;
      pump_r <= 1'b0;
      spark_r <= 1'b0;
      valve_r <= 1'b0;
    end else begin
      blower_r <= (st_r == S_IGNITION) || (st_r == S_FULL) || (st_r == S_COOLDOWN);
      pump_r <= (st_r == S_IGNITION) || (st_r == S_FULL) || (st_r == S_COOLDOWN)
        || (st_r == S_STANDBY);
      spark_r <= ((st_r == S_IGNITION) && tmr_r >= STEP_CYC && !(tmr_r == IGN_CYC - 1'b1))
        || ((st_r == S_PRECHECK) && first_r && tmr_r < SPARK_TEST_CYC - 1'b1);
      // Valve stays open across the move into full output so the flame is not starved
      valve_r <= ((st_r == S_IGNITION) && tmr_r >= 2 * STEP_CYC)
        || (st_r == S_FULL);
      if (st_r == S_FAULT || st_r == S_OFF) begin
        blower_r <= 1'b0;
        pump_r <= 1'b0;
        spark_r <= 1'b0;
        valve_r <= 1'b0;
      end
    end
  end

  // Fault code flasher, only active in fault shutdown
  hbs_flash #(
    .ON_CYC(FLASH_ON_CYC),
    .GAP_CYC(FLASH_GAP_CYC),
    .PAUSE_CYC(FLASH_PAUSE_CYC)
  ) u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .code((st_r == S_FAULT) ? code_r : CODE_NONE),
    .lamp(lamp)
  );

  // Output bundle; auxiliary input forces the pump on
  assign drv.blower = blower_r;
  assign drv.pump = pump_r || sync2_r.aux_pump;
  assign drv.spark = spark_r;
  assign drv.fuel_valve = valve_r;
  assign drv.lamp = lamp;

  // APB threshold registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= START_TEMP_RST;
      high_r <= HIGH_TEMP_RST;
      cycon_r <= CYCLE_ON_RST;
      hyst_r <= HYST_RST;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        OFF_START: start_r <= pwdata[TEMP_W-1:0];
        OFF_HIGH: high_r <= pwdata[TEMP_W-1:0];
        OFF_CYCON: cycon_r <= pwdata[TEMP_W-1:0];
        OFF_HYST: hyst_r <= pwdata[TEMP_W-1:0];
        default: ;
      endcase
    end
  end

  // APB read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_START: prdata <= {20'h00000, start_r};
        OFF_HIGH: prdata <= {20'h00000, high_r};
        OFF_CYCON: prdata <= {20'h00000, cycon_r};
        OFF_HYST: prdata <= {20'h00000, hyst_r};
        OFF_STATUS: prdata <= {11'h000, drv, 4'h0, code_r, 3'h0, att_r, 1'b0, st_r};
        OFF_TEMP: prdata <= {20'h00000, temp_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == OFF_START || paddr == OFF_HIGH
    || paddr == OFF_CYCON || paddr == OFF_HYST || paddr == OFF_STATUS || paddr == OFF_TEMP
    || (pwrite && 1'b0));

endmodule
`default_nettype wire

// ### hbs_seq_props.sv
// Port-level assertions for the heater burner sequencer, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module hbs_seq_props #(
  parameter logic [hbs_pkg::TW-1:0] STEP_CYC = hbs_pkg::STEP_CYC,
  parameter logic [hbs_pkg::TW-1:0] COOL_CYC = hbs_pkg::COOL_CYC,
  parameter logic [hbs_pkg::TW-1:0] FLASH_ON_CYC = hbs_pkg::FLASH_ON_CYC
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire hbs_pkg::hbs_pins_s pins, // Field inputs
  input wire hbs_pkg::hbs_drv_s drv // Actuator drives
);
  import hbs_pkg::*;
  localparam int SP_MAX = int'(STEP_CYC) + 3;
  logic [TW-1:0] on_cnt;
  logic [TW-1:0] off_cnt;
  logic mapped;
  // Decoded register offsets
  assign mapped = paddr inside {OFF_START, OFF_HIGH, OFF_CYCON, OFF_HYST, OFF_STATUS, OFF_TEMP};
  // Length of the current lamp pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_cnt <= '0;
    else on_cnt <= drv.lamp ? on_cnt + 1'b1 : '0;
  end
  // Cycles since the switch went off, saturating past the cool-down span
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_cnt <= '0;
    else if (pins.switch_on) off_cnt <= '0;
    else if (off_cnt < COOL_CYC + 9) off_cnt <= off_cnt + 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr does not match decode");
  a_valve_loads: assert property (drv.fuel_valve |-> drv.blower && drv.pump)
    else $error("fuel valve open without blower and pump");
  a_spark_first: assert property ($rose(drv.fuel_valve) |-> $past(drv.spark))
    else $error("fuel valve opened before spark");
  a_ign_order: assert property ($rose(drv.blower) |->
    !drv.fuel_valve throughout ##[1:SP_MAX] drv.spark)
    else $error("spark late or valve early after blower start");
  a_spark_held: assert property ($rose(drv.fuel_valve) |-> drv.spark [*8])
    else $error("spark dropped early in ignition");
  a_fault_dark: assert property (drv.lamp |-> !(drv.blower || drv.spark || drv.fuel_valve))
    else $error("load energised while lamp flashes");
  a_aux_pump: assert property (pins.aux_pump [*4] |-> drv.pump)
    else $error("aux input does not run pump");
  a_off_quiet: assert property (off_cnt > COOL_CYC + 8 |->
    !(drv.blower || drv.spark || drv.fuel_valve || drv.lamp))
    else $error("loads still on long after switch off");
  a_flash_width: assert property ($fell(drv.lamp) && off_cnt == '0 |-> on_cnt == FLASH_ON_CYC)
    else $error("lamp pulse width wrong");
  // Main scenarios reached
  c_flash: cover property ($rose(drv.lamp));
  c_fuel: cover property ($rose(drv.fuel_valve));
  c_err: cover property (pslverr);
endmodule
bind hbs_seq hbs_seq_props #(.STEP_CYC(STEP_CYC), .COOL_CYC(COOL_CYC),
  .FLASH_ON_CYC(FLASH_ON_CYC)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .drv(drv));
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the heater burner sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hbs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sw, aux, lights;
  logic [7:0] paddr, cfault;
  logic [31:0] pwdata, prdata, rd, rng;
  logic [11:0] temp;
  logic [2:0] sysf;
  logic [11:0] dflt [4];
  hbs_pins_s pins;
  hbs_drv_s drv;
  int err_total, n_checks, n, k;
  hbs_seq #(.SPARK_TEST_CYC(36'h14), .IGN_CYC(36'h32), .COOL_CYC(36'h1e), .STEP_CYC(36'h5),
    .DEB_CYC(36'h3), .FLASH_ON_CYC(36'h4), .FLASH_GAP_CYC(36'h4), .FLASH_PAUSE_CYC(36'ha))
    uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .drv(drv));
  hbs_field u_field (.pclk(pclk), .presetn(presetn), .drv(drv), .sw(sw), .aux(aux),
    .lights(lights), .cfault(cfault), .temp(temp), .sysf(sysf), .pins(pins));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      chk_bit(1'b0, 1'b1);
      give_verdict();
    end
  endtask
  // Poll the status state field under a bound
  task automatic wait_state(input hbs_state_e s);
    int i;
    for (i = 0; i < 100; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rd[2:0] === s) break;
    end
    chk_word({29'h0, rd[2:0]}, {29'h0, s});
    if (rd[2:0] !== s) give_verdict();
  endtask
  // Count lamp pulses in one series, starting after a pause
  task automatic count_flash();
    int lo, i;
    n = 0;
    lo = 0;
    for (i = 0; i < 300 && lo < 8; i++) begin
      @(posedge pclk);
      lo = (drv.lamp === 1'b1) ? 0 : lo + 1;
    end
    for (i = 0; i < 300 && !(n > 0 && lo >= 8); i++) begin
      @(posedge pclk);
      if (drv.lamp === 1'b1 && lo > 0) n++;
      lo = (drv.lamp === 1'b1) ? 0 : lo + 1;
    end
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sw, aux, cfault, sysf} = '0;
    lights = 1'b1;
    temp = 12'h064;
    rng = 32'h281b;
    err_total = 0;
    n_checks = 0;
    dflt = '{12'h0a0, 12'h0b9, 12'h096, 12'h002};
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Threshold registers: reset values, random write and read back, restore
    for (k = 0; k < 4; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk_word(rd, {20'h0, dflt[k]});
      rng = xs(rng);
      apb(1'b1, 8'(k * 4), rng);
      apb(1'b0, 8'(k * 4), 32'h0);
      chk_word(rd, {20'h0, rng[11:0]});
      apb(1'b1, 8'(k * 4), {20'h0, dflt[k]});
    end
    apb(1'b0, 8'h18, 32'h0);
    chk_bit(er, 1'b1);
    chk_word(rd, 32'h0);
    // Cold start with a good flame, run to limit, standby, restart, switch off
    rng = xs(rng);
    temp <= 12'h014 + 12'(rng % 130);
    repeat (10) @(posedge pclk);
    sw <= 1'b1;
    wait_state(S_PRECHECK);
    chk_bit(drv.spark, 1'b1);
    chk_bit(drv.fuel_valve, 1'b0);
    wait_state(S_IGNITION);
    wait_state(S_FULL);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word({27'h0, rd[20:16]}, 32'h1a);
    temp <= 12'h0be;
    wait_state(S_COOLDOWN);
    chk_bit(drv.blower, 1'b1);
    wait_state(S_STANDBY);
    chk_bit(drv.pump, 1'b1);
    chk_bit(drv.blower, 1'b0);
    temp <= 12'h08c;
    wait_state(S_IGNITION);
    // Let spark and valve come on before the switch cuts ignition
    repeat (20) @(posedge pclk);
    sw <= 1'b0;
    wait_state(S_COOLDOWN);
    wait_state(S_OFF);
    // Warm start goes to standby; switch off there is immediate
    temp <= 12'h0aa;
    repeat (10) @(posedge pclk);
    sw <= 1'b1;
    wait_state(S_STANDBY);
    sw <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word({29'h0, rd[2:0]}, {29'h0, S_OFF});
    aux <= 1'b1;
    repeat (5) @(posedge pclk);
    chk_bit(drv.pump, 1'b1);
    aux <= 1'b0;
    // Burner never lights: two attempts, then latched start fault
    rng = xs(rng);
    temp <= 12'h014 + 12'(rng % 130);
    lights <= 1'b0;
    repeat (10) @(posedge pclk);
    sw <= 1'b1;
    wait_state(S_COOLDOWN);
    wait_state(S_IGNITION);
    chk_word({28'h0, rd[11:8]}, 32'h0);
    chk_bit(rd[4], 1'b1);
    wait_state(S_FAULT);
    chk_word({28'h0, rd[11:8]}, 32'h1);
    count_flash();
    chk_word(32'(n), 32'h1);
    lights <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word({29'h0, rd[2:0]}, {29'h0, S_FAULT});
    sw <= 1'b0;
    wait_state(S_OFF);
    sw <= 1'b1;
    wait_state(S_PRECHECK);
    // Component fault during pre-check gives its own code
    cfault <= 8'h08;
    wait_state(S_FAULT);
    chk_word({28'h0, rd[11:8]}, 32'ha);
    count_flash();
    chk_word(32'(n), 32'ha);
    chk_bit(drv.blower, 1'b0);
    cfault <= 8'h00;
    sw <= 1'b0;
    wait_state(S_OFF);
    // Overheat in full output: one retry, then latched overheat code
    sw <= 1'b1;
    wait_state(S_FULL);
    sysf <= 3'b010;
    wait_state(S_COOLDOWN);
    wait_state(S_FAULT);
    chk_word({28'h0, rd[11:8]}, 32'h4);
    count_flash();
    chk_word(32'(n), 32'h4);
    sysf <= 3'b000;
    sw <= 1'b0;
    wait_state(S_OFF);
    give_verdict();
  end
endmodule
`default_nettype wire
